// ===== bsr_pkg.sv
// Constants and types for the bidirectional shift register.
// Assumes a single 100 MHz clock domain.
package bsr_pkg;
    // -------------------------------------------------------------------
    // Sizes and reset values
    // -------------------------------------------------------------------
    localparam int          BSR_WIDTH   = 4;
    localparam logic [3:0]  BSR_RST_VAL = 4'h0;
    localparam int          BSR_SYNC_STAGES = 2;

    // -------------------------------------------------------------------
    // Mode codes: {mode_b, mode_a}
    // -------------------------------------------------------------------
    typedef enum logic [1:0] {
        BSR_HOLD  = 2'b00,
        BSR_LEFT  = 2'b01,
        BSR_RIGHT = 2'b10,
        BSR_LOAD  = 2'b11
    } bsr_mode_e;
endpackage

// ===== bsr_shift_reg.sv
// Bidirectional shift register with load, shift right, shift left and hold.
// Assumes all inputs come from logic clocked by clk, except the clear pin.
`timescale 1ns/1ps
`default_nettype none

module bsr_shift_reg
    import bsr_pkg::*;
#(
    parameter int WIDTH = bsr_pkg::BSR_WIDTH
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset,
    // Asynchronous clear pin
    input  wire logic             clear_n,
    // Mode controls
    input  wire logic             mode_a,
    input  wire logic             mode_b,
    // Data inputs
    input  wire logic             ser_right,
    input  wire logic             ser_left,
    input  wire logic [WIDTH-1:0] par_in,
    // Stage outputs
    output logic      [WIDTH-1:0] stage_q
);
    import bsr_pkg::*;

    // -------------------------------------------------------------------
    // Local constants
    // -------------------------------------------------------------------
    // Contents after reset or clear, sized to the register
    localparam logic [WIDTH-1:0] RST_VAL = WIDTH'(BSR_RST_VAL);

    // -------------------------------------------------------------------
    // Mode decoding
    // -------------------------------------------------------------------
    // Joins the two mode pins into one code; shared by the data path and the checks
    function automatic bsr_mode_e decode_mode(input logic sel_b, input logic sel_a);
        return bsr_mode_e'({sel_b, sel_a});
    endfunction

    // -------------------------------------------------------------------
    // Internal signals
    // -------------------------------------------------------------------
    logic             clr;       // Reset or clear, active high
    bsr_mode_e        mode;      // Mode taken at the next edge
    logic [WIDTH-1:0] stage_d;   // Next contents
    wire  [WIDTH-1:0] from_low;  // Source of each stage on a right shift
    wire  [WIDTH-1:0] from_high; // Source of each stage on a left shift

    // -------------------------------------------------------------------
    // Combined asynchronous clear
    // -------------------------------------------------------------------
    // Clear acts without the clock; the mode pins come from logic on clk and are
    // read directly, the driving logic keeping them away from the rising edge
    assign clr  = reset | ~clear_n;
    assign mode = decode_mode(mode_b, mode_a);

    // -------------------------------------------------------------------
    // Shift paths
    // -------------------------------------------------------------------
    // Stage 0 is the first stage; a right shift moves data toward the last one
    // Each end stage takes a serial pin, every other stage a neighbour
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_path
            // Right shift source: the serial input at the first stage, else the lower neighbour
            if (gi == 0) begin : g_first
                assign from_low[gi] = ser_right;
            end else begin : g_low
                assign from_low[gi] = stage_q[gi-1];
            end
            // Left shift source: the serial input at the last stage, else the upper neighbour
            if (gi == WIDTH-1) begin : g_last
                assign from_high[gi] = ser_left;
            end else begin : g_high
                assign from_high[gi] = stage_q[gi+1];
            end
        end
    endgenerate

    // -------------------------------------------------------------------
    // Next-state selection
    // -------------------------------------------------------------------
    // Picks the next contents for each mode; a load never looks at the serial pins
    always_comb begin
        case (mode)
            BSR_LOAD:  stage_d = par_in;
            BSR_RIGHT: stage_d = from_low;
            BSR_LEFT:  stage_d = from_high;
            BSR_HOLD:  stage_d = stage_q;
            default:   stage_d = stage_q;
        endcase
    end

    // -------------------------------------------------------------------
    // Stage flip-flops
    // -------------------------------------------------------------------
    // Updates on the rising edge unless cleared
    always_ff @(posedge clk or posedge clr) begin
        if (clr) begin
            stage_q <= RST_VAL;
        end else begin
            stage_q <= stage_d;
        end
    end

    // -------------------------------------------------------------------
    // Check helpers
    // -------------------------------------------------------------------
    // Remembers the contents at the start of a run of hold cycles, so that a
    // long hold is checked against one fixed value instead of cycle by cycle
    logic [WIDTH-1:0] held_q;
    logic             held_vld_q;

    // Captures on the first hold cycle, drops the mark on any other mode
    always_ff @(posedge clk or posedge clr) begin
        if (clr) begin
            held_q     <= RST_VAL;
            held_vld_q <= 1'b0;
        end else if (mode == BSR_HOLD) begin
            held_q     <= held_vld_q ? held_q : stage_q;
            held_vld_q <= 1'b1;
        end else begin
            held_vld_q <= 1'b0;
        end
    end

    // -------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------
    // Every check but the clear, reset and clear-release checks sleeps while the register
    // is being cleared, since the contents are then forced from outside
    property p_load;
        @(posedge clk) disable iff (clr)
        (mode_a && mode_b) |=> (stage_q == $past(par_in));
    endproperty
    a_load: assert property (p_load) else $error("Parallel load wrong");

    // The end stages, where a serial bit would enter, follow the parallel data
    property p_load_no_serial;
        @(posedge clk) disable iff (clr)
        (decode_mode(mode_b, mode_a) == BSR_LOAD) |=>
            (stage_q[0] == $past(par_in[0])) && (stage_q[WIDTH-1] == $past(par_in[WIDTH-1]));
    endproperty
    a_load_no_serial: assert property (p_load_no_serial) else $error("Serial data entered on load");

    property p_right;
        @(posedge clk) disable iff (clr)
        (mode_b && !mode_a) |=> (stage_q[WIDTH-1:1] == $past(stage_q[WIDTH-2:0]));
    endproperty
    a_right: assert property (p_right) else $error("Right shift wrong");

    property p_right_fill;
        @(posedge clk) disable iff (clr)
        (mode_b && !mode_a) |=> (stage_q[0] == $past(ser_right));
    endproperty
    a_right_fill: assert property (p_right_fill) else $error("Right fill wrong");

    property p_left;
        @(posedge clk) disable iff (clr)
        (!mode_b && mode_a) |=>
            (stage_q == {$past(ser_left), $past(stage_q[WIDTH-1:1])});
    endproperty
    a_left: assert property (p_left) else $error("Left shift wrong");

    // A left shift fills the last stage from its serial pin
    property p_left_fill;
        @(posedge clk) disable iff (clr)
        (decode_mode(mode_b, mode_a) == BSR_LEFT) |=> (stage_q[WIDTH-1] == $past(ser_left));
    endproperty
    a_left_fill: assert property (p_left_fill) else $error("Left fill wrong");

    property p_hold;
        @(posedge clk) disable iff (clr)
        (!mode_b && !mode_a) [*2] |-> $stable(stage_q);
    endproperty
    a_hold: assert property (p_hold) else $error("Hold changed contents");

    // One hold cycle leaves the contents as they were
    property p_hold_step;
        @(posedge clk) disable iff (clr)
        (decode_mode(mode_b, mode_a) == BSR_HOLD) |=> $stable(stage_q);
    endproperty
    a_hold_step: assert property (p_hold_step) else $error("Hold step changed contents");

    // Over a whole run of hold cycles the contents match those at its start
    property p_hold_run;
        @(posedge clk) disable iff (clr)
        held_vld_q |-> (stage_q == held_q);
    endproperty
    a_hold_run: assert property (p_hold_run) else $error("Long hold drifted");

    property p_clear;
        @(posedge clk)
        (!clear_n) |-> (stage_q == '0);
    endproperty
    a_clear: assert property (p_clear) else $error("Clear not applied");

    // Reset empties the register just as the clear pin does
    property p_reset;
        @(posedge clk)
        reset |-> (stage_q == RST_VAL);
    endproperty
    a_reset: assert property (p_reset) else $error("Reset not applied");

    property p_clear_release;
        @(posedge clk) disable iff (reset)
        $rose(clear_n) && !mode_a && !mode_b |=> (stage_q == '0);
    endproperty
    a_clear_release: assert property (p_clear_release) else $error("Hold after clear lost zero");
endmodule

`default_nettype wire

// ===== bsr_drv.sv
// Partner model: the logic that drives the shift register inputs.
// Assumes callers run in the clk domain.
`timescale 1ns/1ps
`default_nettype none
module bsr_drv
    import bsr_pkg::*;
(
    // Clock
    input  wire logic                        clk,
    // Driven controls and data
    output logic                             mode_a,
    output logic                             mode_b,
    output logic                             ser_right,
    output logic                             ser_left,
    output logic [bsr_pkg::BSR_WIDTH-1:0]    par_in
);
    initial {mode_b, mode_a, ser_right, ser_left, par_in} = '0;
    // Change inputs just after the rising edge, inside the high phase
    task automatic apply(input bsr_mode_e m, input logic sr, input logic sl, input logic [3:0] p);
        @(posedge clk);
        {mode_b, mode_a} <= m;
        ser_right <= sr;
        ser_left <= sl;
        par_in <= p;
    endtask
endmodule
`default_nettype wire

// ===== tb.sv
// Self-checking bench for the bidirectional shift register.
// Assumes bsr_pkg and bsr_drv are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import bsr_pkg::*;
    logic       clk = 1'b0;
    logic       reset = 1'b1;
    logic       clear_n = 1'b1;
    logic       mode_a, mode_b, ser_right, ser_left;
    logic [3:0] par_in, stage_q;
    int         n_fail = 0;
    int         compares = 0;
    bsr_drv drv (.clk(clk), .mode_a(mode_a), .mode_b(mode_b), .ser_right(ser_right), .ser_left(ser_left),
        .par_in(par_in));
    bsr_shift_reg #(.WIDTH(4)) dut (.clk(clk), .reset(reset), .clear_n(clear_n), .mode_a(mode_a),
        .mode_b(mode_b), .ser_right(ser_right), .ser_left(ser_left), .par_in(par_in), .stage_q(stage_q));
    initial forever #5 clk = ~clk;
    task automatic chk(input logic [3:0] exp);
        compares++;
        if (stage_q !== exp) begin
            n_fail++;
            $display("[ERR] stage_q expected %h seen %h", exp, stage_q);
        end
    endtask
    // One mode step, then a hold step with every data input flipped
    task automatic step(input bsr_mode_e m, input logic sr, sl, input logic [3:0] p, exp);
        drv.apply(m, sr, sl, p);
        drv.apply(BSR_HOLD, ~sr, ~sl, ~p);
        #1 chk(exp);
        @(posedge clk) #1 chk(exp);
    endtask
    task automatic t_load;
        step(BSR_LOAD, 1'b1, 1'b1, 4'h6, 4'h6);
        step(BSR_LOAD, 1'b1, 1'b1, 4'hA, 4'hA);
    endtask
    task automatic t_right;
        step(BSR_RIGHT, 1'b1, 1'b0, 4'h0, 4'h5);
        step(BSR_RIGHT, 1'b0, 1'b1, 4'hF, 4'hA);
    endtask
    task automatic t_left;
        step(BSR_LEFT, 1'b0, 1'b1, 4'h0, 4'hD);
        step(BSR_LEFT, 1'b1, 1'b0, 4'hF, 4'h6);
    endtask
    // Mid-run reset empties the register; a clear released while holding keeps it empty
    task automatic t_reset_hold;
        drv.apply(BSR_LOAD, 1'b1, 1'b1, 4'h5);
        drv.apply(BSR_HOLD, 1'b0, 1'b0, 4'hA);
        #1 chk(4'h5);
        @(posedge clk) reset <= 1'b1;
        #1 chk(4'h0);
        @(posedge clk) reset <= 1'b0;
        #1 chk(4'h0);
        drv.apply(BSR_LOAD, 1'b0, 1'b0, 4'h3);
        #1 chk(4'h0);
        drv.apply(BSR_HOLD, 1'b1, 1'b1, 4'hC);
        #1 chk(4'h3);
        @(posedge clk) clear_n <= 1'b0;
        #1 chk(4'h0);
        @(posedge clk) clear_n <= 1'b1;
        #1 chk(4'h0);
        @(posedge clk) #1 chk(4'h0);
        @(posedge clk) #1 chk(4'h0);
    endtask
    // Clear wins over a load, and the first edge after release loads
    task automatic t_clear;
        drv.apply(BSR_LOAD, 1'b1, 1'b1, 4'hF);
        @(posedge clk) clear_n <= 1'b0;
        #1 chk(4'h0);
        @(posedge clk) #1 chk(4'h0);
        @(posedge clk) clear_n <= 1'b1;
        #1 chk(4'h0);
        @(posedge clk) #1 chk(4'hF);
    endtask
    task automatic final_report;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        #1 chk(4'h0);
        t_load;
        t_right;
        t_left;
        t_reset_hold;
        t_clear;
        final_report;
    end
    initial begin
        repeat (500) @(posedge clk);
        n_fail++;
        final_report;
    end
endmodule
`default_nettype wire
